/* core/dms_channel.sv */
// Purpose: Transfer sequencer for one DMA channel
// Assumes: Software programs addresses and count before enabling
// Notes: Bus side is a simple read then write handshake; one beat each
//
// Functional notes
// - One byte or word moves per accepted request outside block mode, for the programmed count
// - Each channel instance picks its own mode from its own port
// - Outside normal and block modes, serial receive-full trigger reads peripheral, writes memory; else reverse
// - Memory address steps up or down once after each transfer, except in idle mode
// - Peripheral address is all ones above an 8-bit low byte, never changes
// - Sixteen-bit count decrements by one after every transfer, or after every block in block mode
// - Count reaching zero clears channel enable and stops the channel in every mode but repeat
// - Completion interrupt only when completion interrupt enable is one
// - Count loaded with zero runs 65,536 transfers
// - Requests from timers 0 to 3, serial empty/full, external request
// - Idle mode holds both addresses fixed
// - Repeat mode restores start address and count, keeps running
// - Repeat mode never raises an interrupt
// - Auto-request normal mode runs without trigger until count done
// - Cycle-steal releases the bus after each transfer
// - Burst holds the bus until done unless higher master asks
// - Normal and block modes use full 24-bit source and destination
// - Block mode moves one block per request for the block count
// - Block end restores one address; interrupt possible when all done
// - Byte steps address by one, word steps by two
`timescale 1ns/1ps
module dms_channel
   import dms_pkg::*;
(
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire dms_mode_t mode,
   input wire dms_src_t trig_select,
   input wire logic burst_mode,
   input wire logic step_enable,
   input wire logic step_down,
   input wire logic transfer_size_bit,
   input wire logic completion_irq_enable,
   input wire logic block_src_side,
   input wire logic load,
   input wire logic [23:0] memory_address_in,
   input wire logic [23:0] dest_address_in,
   input wire logic [7:0] peripheral_address_in,
   input wire logic [15:0] transfer_count_in,
   input wire logic [7:0] block_size_in,
   input wire logic enable_set,
   input wire logic enable_clear,
   input wire logic [6:0] trig_events,
   input wire logic ext_request_n,
   input wire logic higher_master_req,
   output logic channel_enable_bit,
   output logic completion_irq,
   output logic bus_req,
   output logic bus_rd,
   output logic bus_wr,
   output logic [23:0] bus_addr,
   output logic [15:0] bus_wdata,
   input wire logic bus_ack,
   input wire logic [15:0] bus_rdata,
   output logic [23:0] memory_address_reg,
   output logic [15:0] transfer_count_reg
);
   // ****************************************************************
   // Registers and synchronisers
   // ****************************************************************
   typedef enum logic [2:0] {ST_IDLE, ST_READ, ST_PUSH, ST_WRITE, ST_DONE}
      dms_state_t;
   dms_state_t state;
   logic [23:0] dest_address_reg, start_mem, start_dest, next_mem, next_dest;
   logic [15:0] start_count, next_count, buf_out_data, rd_word;
   logic [7:0] peripheral_address_reg, block_left, block_size;
   logic ext_meta, ext_sync, ext_prev, dir_rx, pending, last_xfer;
   logic block_end, req_hit, rd_src_ready, buf_out_valid, mem_step, full_addr;
   // External request crosses in from a pin
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         ext_meta <= 1'b0;
         ext_sync <= 1'b0;
         ext_prev <= 1'b0;
      end
      else
      begin
         ext_meta <= ~ext_request_n;
         ext_sync <= ext_meta;
         ext_prev <= ext_sync;
      end
   end

   // ****************************************************************
   // Request selection
   // ****************************************************************
   function automatic logic trig_hit(input dms_src_t sel,
                                     input logic [6:0] ev,
                                     input logic ext_edge);
      case (sel)
         DMS_SRC_TMR0, DMS_SRC_TMR1, DMS_SRC_TMR2, DMS_SRC_TMR3:
            trig_hit = ev[3'(sel)];
         DMS_SRC_TXE: trig_hit = ev[DMS_TRG_TXE];
         DMS_SRC_RXF: trig_hit = ev[DMS_TRG_RXF];
         DMS_SRC_EXT: trig_hit = ext_edge | ev[DMS_TRG_EXT];
         default: trig_hit = 1'b0;
      endcase
   endfunction
   assign full_addr = (mode == DMS_MODE_NORMAL) || (mode == DMS_MODE_BLOCK);
   assign req_hit = trig_hit(trig_select, trig_events,
                             ext_sync && !ext_prev);
   assign mem_step = step_enable && (mode != DMS_MODE_IDLE);
   assign last_xfer = (transfer_count_reg == 16'h0001);
   assign block_end = (mode == DMS_MODE_BLOCK) && (block_left == 8'h01);
   assign next_count = transfer_count_reg - 16'h0001;
   dms_addr_step u_mem_step
   (
      .addr(memory_address_reg),
      .step_en(mem_step),
      .step_down(step_down),
      .size_word(transfer_size_bit),
      .next_addr(next_mem)
   );
   dms_addr_step u_dest_step
   (
      .addr(dest_address_reg),
      .step_en(step_enable && full_addr),
      .step_down(step_down),
      .size_word(transfer_size_bit),
      .next_addr(next_dest)
   );
   dms_buf2 u_buf
   (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .in_valid(state == ST_PUSH),
      .in_ready(rd_src_ready),
      .in_data(rd_word),
      .out_valid(buf_out_valid),
      .out_ready(state == ST_WRITE && bus_ack),
      .out_data(buf_out_data)
   );
   // Pending request latch; a new request wins over its consumption
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
         pending <= 1'b0;
      else if (req_hit && channel_enable_bit)
         pending <= 1'b1;
      else if (state == ST_IDLE && pending)
         pending <= 1'b0;
   end

   // ****************************************************************
   // Sequencer
   // ****************************************************************
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         state <= ST_IDLE;
         dir_rx <= 1'b0;
         bus_req <= 1'b0;
         bus_rd <= 1'b0;
         bus_wr <= 1'b0;
         bus_addr <= DMS_ADDR_RST;
         bus_wdata <= DMS_CNT_RST;
         rd_word <= DMS_CNT_RST;
      end
      else
      begin
         case (state)
            ST_IDLE:
            begin
               bus_req <= bus_req && burst_mode && !higher_master_req
                  && channel_enable_bit;
               if (channel_enable_bit && (pending || (mode == DMS_MODE_BLOCK
                  && block_left != block_size) || (mode == DMS_MODE_NORMAL
                  && trig_select == DMS_SRC_AUTO)))
               begin
                  dir_rx <= (trig_select == DMS_SRC_RXF) && !full_addr;
                  state <= ST_READ;
                  bus_req <= 1'b1;
                  bus_rd <= 1'b1;
                  bus_addr <= (trig_select == DMS_SRC_RXF && !full_addr)
                     ? {DMS_IO_HIGH, peripheral_address_reg}
                     : memory_address_reg;
               end
            end
            ST_READ:
               if (bus_ack)
               begin
                  bus_rd <= 1'b0;
                  rd_word <= bus_rdata;
                  state <= ST_PUSH;
               end
            ST_PUSH:
               if (rd_src_ready)
               begin
                  state <= ST_WRITE;
                  bus_wr <= 1'b1;
                  bus_wdata <= rd_word;
                  if (full_addr)
                     bus_addr <= dest_address_reg;
                  else if (dir_rx)
                     bus_addr <= memory_address_reg;
                  else
                     bus_addr <= {DMS_IO_HIGH, peripheral_address_reg};
               end
            ST_WRITE:
            begin
               bus_wdata <= buf_out_data;
               if (bus_ack && buf_out_valid)
               begin
                  bus_wr <= 1'b0;
                  bus_req <= burst_mode && !higher_master_req;
                  state <= ST_DONE;
               end
            end
            ST_DONE:
               state <= ST_IDLE;
            default:
               state <= ST_IDLE;
         endcase
      end
   end

   // ****************************************************************
   // Address, count and enable
   // ****************************************************************
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         memory_address_reg <= DMS_ADDR_RST;
         dest_address_reg <= DMS_ADDR_RST;
         peripheral_address_reg <= DMS_IOA_RST;
         transfer_count_reg <= DMS_CNT_RST;
         start_mem <= DMS_ADDR_RST;
         start_dest <= DMS_ADDR_RST;
         start_count <= DMS_CNT_RST;
         block_size <= DMS_RPT_RST;
         block_left <= DMS_RPT_RST;
      end
      else if (load && !channel_enable_bit)
      begin
         memory_address_reg <= memory_address_in;
         dest_address_reg <= dest_address_in;
         peripheral_address_reg <= peripheral_address_in;
         transfer_count_reg <= transfer_count_in;
         start_mem <= memory_address_in;
         start_dest <= dest_address_in;
         start_count <= transfer_count_in;
         block_size <= block_size_in;
         block_left <= block_size_in;
      end
      else if (state == ST_DONE)
      begin
         memory_address_reg <= next_mem;
         dest_address_reg <= next_dest;
         if (mode == DMS_MODE_BLOCK && !block_end)
            block_left <= block_left - 8'h01;
         else
         begin
            transfer_count_reg <= next_count;
            block_left <= block_size;
            if (block_end && block_src_side)
               memory_address_reg <= start_mem;
            else if (block_end)
               dest_address_reg <= start_dest;
            if (mode == DMS_MODE_REPEAT && last_xfer)
            begin
               memory_address_reg <= start_mem;
               transfer_count_reg <= start_count;
            end
         end
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         channel_enable_bit <= 1'b0;
         completion_irq <= 1'b0;
      end
      else
      begin
         completion_irq <= 1'b0;
         if (state == ST_DONE && last_xfer && mode != DMS_MODE_REPEAT
            && (mode != DMS_MODE_BLOCK || block_end))
         begin
            channel_enable_bit <= 1'b0;
            completion_irq <= completion_irq_enable;
         end
         else if (enable_set)
            channel_enable_bit <= 1'b1;
         else if (enable_clear)
            channel_enable_bit <= 1'b0;
      end
   end

   // ****************************************************************
   // Checks
   // ****************************************************************
   sequence s_xfer_end;
      state == ST_DONE && last_xfer && mode == DMS_MODE_IO;
   endsequence
   a_count_stop: assert property (@(posedge core_clk) disable iff (sys_rst)
      s_xfer_end |=> !channel_enable_bit)
      else $error("channel still enabled after last transfer");
   a_irq_gate: assert property (@(posedge core_clk) disable iff (sys_rst)
      s_xfer_end |=> completion_irq == $past(completion_irq_enable))
      else $error("completion interrupt gating wrong");
   a_repeat_noirq: assert property (@(posedge core_clk) disable iff (sys_rst)
      mode == DMS_MODE_REPEAT && $stable(mode) |=> !completion_irq)
      else $error("interrupt raised in repeat mode");
   a_count_step: assert property (@(posedge core_clk) disable iff (sys_rst)
      state == ST_DONE && mode == DMS_MODE_IO && !last_xfer && !load
      |=> transfer_count_reg == $past(transfer_count_reg) - 16'h0001)
      else $error("count did not step by one");
   a_io_high: assert property (@(posedge core_clk) disable iff (sys_rst)
      state == ST_WRITE && !full_addr && !dir_rx
      |-> bus_addr[23:8] == DMS_IO_HIGH)
      else $error("peripheral address upper bits not ones");
   a_rx_dir: assert property (@(posedge core_clk) disable iff (sys_rst)
      state == ST_READ && dir_rx |-> bus_addr[23:8] == DMS_IO_HIGH)
      else $error("receive trigger did not read peripheral");
   a_idle_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
      state == ST_DONE && mode == DMS_MODE_IDLE && !load
      |=> $stable(memory_address_reg))
      else $error("idle mode moved memory address");
   a_mem_step: assert property (@(posedge core_clk) disable iff (sys_rst)
      state == ST_DONE && mode == DMS_MODE_IO && step_enable && step_down
      && !transfer_size_bit && !load
      |=> memory_address_reg == $past(memory_address_reg) - 24'h000001)
      else $error("memory address step wrong");
endmodule

/* core/dms_pkg.sv */
// Purpose: Constants and types for the DMA channel sequencer
// Assumes: 100 MHz core clock, one channel per instance
// Notes: Modes, trigger codes and field positions shared by all files but the bus model
package dms_pkg;
   // ****************************************************************
   // Widths and fixed values
   // ****************************************************************
   localparam int DMS_ADDR_W = 24;
   localparam int DMS_CNT_W = 16;
   localparam int DMS_IOA_W = 8;
   localparam logic [15:0] DMS_IO_HIGH = 16'hffff;
   localparam logic [15:0] DMS_CNT_RST = 16'h0000;
   localparam logic [23:0] DMS_ADDR_RST = 24'h000000;
   localparam logic [7:0] DMS_IOA_RST = 8'h00;
   localparam logic [7:0] DMS_RPT_RST = 8'h00;
   localparam logic [23:0] DMS_STEP_BYTE = 24'h000001;
   localparam logic [23:0] DMS_STEP_WORD = 24'h000002;
   localparam logic [1:0] DMS_BUF_DEPTH = 2'h2;
   // Bit layout of the trigger vector
   localparam int DMS_TRG_TMR0 = 0;
   localparam int DMS_TRG_TMR3 = 3;
   localparam int DMS_TRG_TXE = 4;
   localparam int DMS_TRG_RXF = 5;
   localparam int DMS_TRG_EXT = 6;
   localparam int DMS_TRG_W = 7;
   // ****************************************************************
   // Enumerations
   // ****************************************************************
   typedef enum logic [2:0]
   {
      DMS_MODE_IO,
      DMS_MODE_IDLE,
      DMS_MODE_REPEAT,
      DMS_MODE_NORMAL,
      DMS_MODE_BLOCK
   } dms_mode_t;
   typedef enum logic [2:0]
   {
      DMS_SRC_TMR0,
      DMS_SRC_TMR1,
      DMS_SRC_TMR2,
      DMS_SRC_TMR3,
      DMS_SRC_TXE,
      DMS_SRC_RXF,
      DMS_SRC_EXT,
      DMS_SRC_AUTO
   } dms_src_t;
endpackage

/* core/dms_addr_step.sv */
// Purpose: Next-address arithmetic for a stepping address register
// Assumes: Combinational, used by the channel sequencer
// Notes: Byte steps by one, word steps by two
`timescale 1ns/1ps
module dms_addr_step
   import dms_pkg::*;
(
   input wire logic [23:0] addr,
   input wire logic step_en,
   input wire logic step_down,
   input wire logic size_word,
   output logic [23:0] next_addr
);
   // ****************************************************************
   // Step arithmetic
   // ****************************************************************
   function automatic logic [23:0] step_of(input logic word);
      step_of = word ? DMS_STEP_WORD : DMS_STEP_BYTE;
   endfunction

   always_comb
   begin
      next_addr = addr;
      if (step_en)
      begin
         if (step_down)
            next_addr = addr - step_of(size_word);
         else
            next_addr = addr + step_of(size_word);
      end
   end
endmodule

/* core/dms_buf2.sv */
// Purpose: Two-entry valid/ready buffer for transfer words
// Assumes: Single clock, synchronous active-high reset
// Notes: Full and empty are exact; in_ready drops when both slots hold
`timescale 1ns/1ps
module dms_buf2
   import dms_pkg::*;
(
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [15:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [15:0] out_data
);
   // ****************************************************************
   // Storage
   // ****************************************************************
   logic [15:0] mem [2];
   logic wr_ptr;
   logic rd_ptr;
   logic [1:0] count;
   logic push;
   logic pop;

   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign in_ready = (count != DMS_BUF_DEPTH);
   assign out_valid = (count != 2'h0);
   assign out_data = mem[rd_ptr];

   always_ff @(posedge core_clk)
   begin
      if (push)
         mem[wr_ptr] <= in_data;
   end

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         wr_ptr <= 1'b0;
         rd_ptr <= 1'b0;
         count <= 2'h0;
      end
      else
      begin
         if (push)
            wr_ptr <= ~wr_ptr;
         if (pop)
            rd_ptr <= ~rd_ptr;
         count <= count + {1'b0, push} - {1'b0, pop};
      end
   end
endmodule

/* testbench/dms_bus_model.sv */
// Purpose: System bus responder facing the channel sequencer
// Assumes: One read or write held by the sequencer until acknowledged
// Notes: Records the last read and write; slow adds wait cycles
`timescale 1ns/1ps
module dms_bus_model
(
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic slow,
   input wire logic bus_rd,
   input wire logic bus_wr,
   input wire logic [23:0] bus_addr,
   input wire logic [15:0] bus_wdata,
   output logic bus_ack,
   output logic [15:0] bus_rdata,
   output logic [23:0] rd_addr,
   output logic [23:0] wr_addr,
   output logic [15:0] wr_data,
   output logic [15:0] n_wr
);
   logic [2:0] wait_cnt;
   logic [15:0] noise;
   // ****************************************************************
   // Answer
   // ****************************************************************
   // Read data is only valid in the ack cycle; a changing pattern
   // otherwise, so a late sample shows up as a wrong word
   always_ff @(posedge core_clk)
   begin
      noise <= noise + 16'h3c5b;
      if (sys_rst)
      begin
         bus_ack <= 1'b0;
         wait_cnt <= 3'h0;
         n_wr <= 16'h0000;
         bus_rdata <= 16'h0000;
         noise <= 16'h1234;
      end
      else if ((bus_rd || bus_wr) && !bus_ack)
      begin
         bus_rdata <= noise;
         if (wait_cnt >= (slow ? 3'h4 : 3'h0))
         begin
            bus_ack <= 1'b1;
            wait_cnt <= 3'h0;
            if (bus_rd)
            begin
               rd_addr <= bus_addr;
               bus_rdata <= bus_addr[15:0] ^ 16'h5a5a;
            end
            else
            begin
               wr_addr <= bus_addr;
               wr_data <= bus_wdata;
               n_wr <= n_wr + 16'h0001;
            end
         end
         else
            wait_cnt <= wait_cnt + 3'h1;
      end
      else
      begin
         bus_ack <= 1'b0;
         bus_rdata <= noise;
      end
   end
endmodule

/* testbench/dms_channel_test.sv */
// Purpose: Self-checking bench for the channel sequencer
// Assumes: Bus responder model on the bus side
// Notes: A count of 65,536 is only checked at its first step
`timescale 1ns/1ps
module dms_channel_test;
   import dms_pkg::*;
   logic core_clk, sys_rst, burst_mode, step_enable, step_down;
   logic transfer_size_bit, completion_irq_enable, block_src_side, load;
   logic enable_set, enable_clear, ext_request_n, higher_master_req;
   logic slow, channel_enable_bit, completion_irq, bus_req, bus_rd;
   logic bus_wr, bus_ack;
   dms_mode_t mode;
   dms_src_t trig_select;
   logic [23:0] memory_address_in, dest_address_in, bus_addr;
   logic [23:0] memory_address_reg, rd_addr, wr_addr, ma;
   logic [7:0] peripheral_address_in, block_size_in;
   logic [15:0] transfer_count_in, bus_wdata, bus_rdata, wr_data, n_wr;
   logic [15:0] transfer_count_reg, mask, n0, irq0;
   logic [6:0] trig_events;
   int fails, num_checks, irq_cnt, k;
   localparam logic [23:0] PIO = {16'hffff, 8'h40};
   dms_channel u_dut (.core_clk(core_clk), .sys_rst(sys_rst),
      .mode(mode), .trig_select(trig_select), .burst_mode(burst_mode),
      .step_enable(step_enable), .step_down(step_down),
      .transfer_size_bit(transfer_size_bit),
      .completion_irq_enable(completion_irq_enable),
      .block_src_side(block_src_side), .load(load),
      .memory_address_in(memory_address_in),
      .dest_address_in(dest_address_in),
      .peripheral_address_in(peripheral_address_in),
      .transfer_count_in(transfer_count_in),
      .block_size_in(block_size_in), .enable_set(enable_set),
      .enable_clear(enable_clear), .trig_events(trig_events),
      .ext_request_n(ext_request_n),
      .higher_master_req(higher_master_req),
      .channel_enable_bit(channel_enable_bit),
      .completion_irq(completion_irq), .bus_req(bus_req),
      .bus_rd(bus_rd), .bus_wr(bus_wr), .bus_addr(bus_addr),
      .bus_wdata(bus_wdata), .bus_ack(bus_ack), .bus_rdata(bus_rdata),
      .memory_address_reg(memory_address_reg),
      .transfer_count_reg(transfer_count_reg));
   dms_bus_model u_bus (.core_clk(core_clk), .sys_rst(sys_rst),
      .slow(slow), .bus_rd(bus_rd), .bus_wr(bus_wr), .bus_addr(bus_addr),
      .bus_wdata(bus_wdata), .bus_ack(bus_ack), .bus_rdata(bus_rdata),
      .rd_addr(rd_addr), .wr_addr(wr_addr), .wr_data(wr_data),
      .n_wr(n_wr));
   // ****************************************************************
   // Clock, interrupt count, watchdog
   // ****************************************************************
   initial
   begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   always @(posedge core_clk)
      if (completion_irq === 1'b1)
         irq_cnt++;
   initial
   begin
      #300000;
      fails++;
      close_out;
   end
   // ****************************************************************
   // Tasks
   // ****************************************************************
   task automatic tick;
      @(posedge core_clk);
      #1;
   endtask
   task automatic check(input logic [23:0] seen, input logic [23:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         fails++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic close_out;
      $display("checks %0d fails %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // Registers only load while disabled, so clear first
   task automatic setup(input dms_mode_t md, input dms_src_t src,
                        input logic sz, input logic dn, input logic ie,
                        input logic [15:0] cnt);
      enable_clear = 1'b1;
      tick;
      enable_clear = 1'b0;
      mode = md;
      trig_select = src;
      transfer_size_bit = sz;
      mask = sz ? 16'hffff : 16'h00ff;
      step_down = dn;
      completion_irq_enable = ie;
      memory_address_in = ma;
      transfer_count_in = cnt;
      irq0 = irq_cnt;
      load = 1'b1;
      tick;
      load = 1'b0;
      enable_set = 1'b1;
      tick;
      enable_set = 1'b0;
   endtask
   task automatic pulse(input int b);
      n0 = n_wr;
      if (b == DMS_TRG_EXT)
         ext_request_n = 1'b0;
      else
         trig_events[b] = 1'b1;
      tick;
      trig_events = 7'h00;
      ext_request_n = 1'b1;
   endtask
   task automatic xfer(input int b, input logic [23:0] er,
                       input logic [23:0] ew);
      pulse(b);
      k = 0;
      while (n_wr == n0 && k < 100)
      begin
         tick;
         k++;
      end
      repeat (4) tick;
      check(n_wr - n0, 24'h1);
      check(rd_addr, er);
      check(wr_addr, ew);
      check(wr_data & mask, (er[15:0] ^ 16'h5a5a) & mask);
      check(bus_req, 24'h0);
   endtask
   task automatic drain;
      k = 0;
      while (channel_enable_bit !== 1'b0 && k < 200)
      begin
         tick;
         k++;
      end
      repeat (4) tick;
   endtask
   // ****************************************************************
   // Tests
   // ****************************************************************
   initial
   begin
      {burst_mode, step_down, transfer_size_bit, load, slow} = 5'h00;
      {completion_irq_enable, block_src_side, enable_set} = 3'h0;
      {enable_clear, higher_master_req} = 2'h0;
      step_enable = 1'b1;
      ext_request_n = 1'b1;
      mode = DMS_MODE_IO;
      trig_select = DMS_SRC_TMR0;
      trig_events = 7'h00;
      block_size_in = 8'h04;
      memory_address_in = 24'h000000;
      dest_address_in = 24'h200010;
      peripheral_address_in = 8'h40;
      transfer_count_in = 16'h0000;
      {fails, num_checks, irq_cnt} = 0;
      ma = 24'h001000;
      sys_rst = 1'b1;
      repeat (3) @(posedge core_clk);
      #1;
      sys_rst = 1'b0;
      check(channel_enable_bit, 24'h0);
      check(bus_req, 24'h0);
      // Every trigger source, word steps up, slow bus on odd ones
      for (int i = 0; i < DMS_TRG_W; i++)
      begin
         slow = i[0];
         setup(DMS_MODE_IO, dms_src_t'(i), 1'b1, 1'b0, 1'b1, 16'h0002);
         for (int j = 0; j < 2; j++)
         begin
            if (i == DMS_TRG_RXF)
               xfer(i, PIO, ma + 2 * j);
            else
               xfer(i, ma + 2 * j, PIO);
            check(memory_address_reg, ma + 2 * (j + 1));
            check(transfer_count_reg, 1 - j);
         end
         check(channel_enable_bit, 24'h0);
         check(irq_cnt - irq0, 24'h1);
         repeat (10) tick;
         pulse(i);
         repeat (12) tick;
         check(n_wr, n0);
      end
      // Byte steps down, interrupt disabled
      ma = 24'h000800;
      setup(DMS_MODE_IO, DMS_SRC_TMR2, 1'b0, 1'b1, 1'b0, 16'h0001);
      xfer(DMS_TRG_TMR0 + 2, ma, PIO);
      check(memory_address_reg, ma - 1);
      check(channel_enable_bit, 24'h0);
      check(irq_cnt - irq0, 24'h0);
      // Idle mode holds both addresses
      setup(DMS_MODE_IDLE, DMS_SRC_TMR1, 1'b1, 1'b0, 1'b1, 16'h0002);
      xfer(1, ma, PIO);
      xfer(1, ma, PIO);
      check(memory_address_reg, ma);
      // Count of zero keeps running after the first step
      setup(DMS_MODE_IO, DMS_SRC_TMR3, 1'b1, 1'b0, 1'b1, 16'h0000);
      xfer(3, ma, PIO);
      check(transfer_count_reg, 24'h00ffff);
      check(channel_enable_bit, 24'h1);
      // Repeat mode reloads and never interrupts
      setup(DMS_MODE_REPEAT, DMS_SRC_TXE, 1'b1, 1'b0, 1'b1, 16'h0002);
      xfer(DMS_TRG_TXE, ma, PIO);
      xfer(DMS_TRG_TXE, ma + 2, PIO);
      check(transfer_count_reg, 24'h2);
      check(memory_address_reg, ma);
      check(channel_enable_bit, 24'h1);
      check(irq_cnt - irq0, 24'h0);
      // Auto-request normal mode starts with no trigger
      n0 = n_wr;
      setup(DMS_MODE_NORMAL, DMS_SRC_AUTO, 1'b1, 1'b0, 1'b1, 16'h0002);
      drain;
      check(n_wr - n0, 24'h2);
      check(rd_addr, ma + 2);
      check(wr_addr[23:8], 24'h2000);
      check(irq_cnt - irq0, 24'h1);
      // Block mode: one request moves the whole block of four words
      block_src_side = 1'b1;
      setup(DMS_MODE_BLOCK, DMS_SRC_TMR0, 1'b1, 1'b0, 1'b1, 16'h0001);
      pulse(DMS_TRG_TMR0);
      drain;
      check(n_wr - n0, 24'h4);
      check(rd_addr, ma + 6);
      check(wr_addr, 24'h200016);
      check(memory_address_reg, ma);
      check(irq_cnt - irq0, 24'h1);
      close_out;
   end
endmodule
